// ==== verilog/arc_cfg.svh ====
`ifndef ARC_CFG_SVH
`define ARC_CFG_SVH

// Register byte offsets on the AXI4-Lite bus
`define ARC_OFF_SC1 8'h00
`define ARC_OFF_CFG 8'h04
`define ARC_OFF_RHI 8'h08
`define ARC_OFF_RLO 8'h0C
`define ARC_OFF_ISTS 8'h10
`define ARC_OFF_IMSK 8'h14

// Status/control field positions
`define ARC_SC1_CH_MSB 4
`define ARC_SC1_CONT_BIT 5
`define ARC_SC1_AIEN_BIT 6
`define ARC_SC1_FLAG_BIT 7

// Configuration field positions
`define ARC_CFG_RES_MSB 1
`define ARC_CFG_ASYNC_BIT 2

// Channel code that turns the converter off, also the reset channel
`define ARC_CH_OFF 5'h1F

// Interrupt status bit positions and width
`define ARC_IRQ_DONE 0
`define ARC_IRQ_OVR 1
`define ARC_IRQ_W 2

// Reset values
`define ARC_RES_RST 2'h0
`define ARC_IMSK_RST 2'h0

// Bus responses
`define ARC_RESP_OKAY 2'h0
`define ARC_RESP_SLVERR 2'h2

`endif

// ==== verilog/arc_pkg.sv ====
package arc_pkg;

   typedef enum logic [1:0] {
      ARC_RES_8 = 2'b00,
      ARC_RES_12 = 2'b01,
      ARC_RES_10 = 2'b10
   } arc_res_t;

endpackage : arc_pkg

// ==== verilog/arc_sync.sv ====
`timescale 1ns/1ps

// Carries a completion toggle from the converter clock into the bus clock
module arc_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tgl_i,
   output logic pulse_o
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic s1_nxt;
   logic s2_nxt;
   logic s3_nxt;

   always_comb begin
      s1_nxt = tgl_i;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
      end
   end

   // Edge taken between the second and third stage only
   assign pulse_o = s2_r ^ s3_r;

endmodule : arc_sync

// ==== verilog/arc_core.sv ====
// How it works
// - Status/control write clears the complete flag; a same-cycle completion keeps it set.
// - Flag still set after that write with interrupts enabled raises the interrupt at once.
// - High-byte read in 10/12-bit mode freezes the low byte of that same conversion.
// - Freeze holds even when a conversion completes on the high-byte read cycle.
// - In 8-bit mode the single result byte is returned directly, never frozen.
// - Single mode starts a conversion only on a software write.
// - Converter runs on bus clock or an asynchronous clock, crossing synchronised.
// - Status/control write sets channel, mode, interrupt enable, off, and starts a conversion unless the channel is off.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "arc_cfg.svh"

module arc_core #(
   parameter int AW = 8,
   parameter int RW = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [AW-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [AW-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic conv_done_i,
   input wire logic conv_done_tgl_i,
   input wire logic [RW-1:0] conv_data_i,
   output logic conv_start_o,
   output logic conv_on_o,
   output logic conv_cont_o,
   output logic [4:0] conv_chan_o,
   output logic [1:0] conv_res_o,
   output logic conv_clk_async_o,
   output logic irq_o
);

   logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
   logic [AW-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic wstrb0_r, wstrb0_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [4:0] ch_r, ch_nxt;
   logic cont_r, cont_nxt, aien_r, aien_nxt, flag_r, flag_nxt;
   arc_pkg::arc_res_t res_r, res_nxt;
   logic async_r, async_nxt, frozen_r, frozen_nxt, start_r, start_nxt;
   logic [RW-1:0] result_r, result_nxt;
   logic [7:0] lo_hold_r, lo_hold_nxt;
   logic [`ARC_IRQ_W-1:0] ists_r, ists_nxt, imsk_r, imsk_nxt, ists_set;
   logic sync_pulse, done_evt, accept;
   logic aw_take, w_take, aw_have, w_have, wr_en, rd_en;
   logic [AW-1:0] wr_addr;
   logic [31:0] wr_data;
   logic wr_b0, wr_sc1, wr_cfg, wr_hit, rd_hi, rd_lo;
   logic [RW-1:0] conv_masked;

   arc_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tgl_i(conv_done_tgl_i),
      .pulse_o(sync_pulse)
   );

   // Bus-clock completions come straight in; asynchronous ones only via the synchroniser
   assign done_evt = async_r ? sync_pulse : conv_done_i;
   assign accept = done_evt && (ch_r != `ARC_CH_OFF);

   assign s_axi_awready_o = !aw_ok_r && !bvalid_r;
   assign s_axi_wready_o = !w_ok_r && !bvalid_r;
   assign s_axi_arready_o = !rvalid_r;
   assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
   assign w_take = s_axi_wvalid_i && s_axi_wready_o;
   assign aw_have = aw_ok_r || aw_take;
   assign w_have = w_ok_r || w_take;
   assign wr_en = aw_have && w_have && !bvalid_r;
   assign wr_addr = aw_ok_r ? awaddr_r : s_axi_awaddr_i;
   assign wr_data = w_ok_r ? wdata_r : s_axi_wdata_i;
   assign wr_b0 = w_ok_r ? wstrb0_r : s_axi_wstrb_i[0];
   assign wr_sc1 = wr_en && wr_b0 && (wr_addr == `ARC_OFF_SC1);
   assign wr_cfg = wr_en && wr_b0 && (wr_addr == `ARC_OFF_CFG);
   assign wr_hit = (wr_addr == `ARC_OFF_SC1) || (wr_addr == `ARC_OFF_CFG) ||
                   (wr_addr == `ARC_OFF_ISTS) || (wr_addr == `ARC_OFF_IMSK);
   assign rd_en = s_axi_arvalid_i && s_axi_arready_o;
   assign rd_hi = rd_en && (s_axi_araddr_i == `ARC_OFF_RHI);
   assign rd_lo = rd_en && (s_axi_araddr_i == `ARC_OFF_RLO);

   always_comb begin
      unique case (res_r)
         arc_pkg::ARC_RES_8: conv_masked = {4'h0, conv_data_i[7:0]};
         arc_pkg::ARC_RES_10: conv_masked = {2'h0, conv_data_i[9:0]};
         arc_pkg::ARC_RES_12: conv_masked = conv_data_i;
         default: conv_masked = conv_data_i;
      endcase
   end

   always_comb begin
      aw_ok_nxt = aw_ok_r;
      w_ok_nxt = w_ok_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb0_nxt = wstrb0_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      ch_nxt = ch_r;
      cont_nxt = cont_r;
      aien_nxt = aien_r;
      res_nxt = res_r;
      async_nxt = async_r;
      imsk_nxt = imsk_r;
      start_nxt = 1'b0;
      result_nxt = result_r;
      lo_hold_nxt = lo_hold_r;
      frozen_nxt = frozen_r;
      flag_nxt = flag_r;
      ists_set = '0;
      ists_nxt = ists_r;
      // Address and data may arrive in either order; each is parked until both are here
      if (aw_take && !wr_en) begin
         aw_ok_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr_i;
      end
      if (w_take && !wr_en) begin
         w_ok_nxt = 1'b1;
         wdata_nxt = s_axi_wdata_i;
         wstrb0_nxt = s_axi_wstrb_i[0];
      end
      if (wr_en) begin
         aw_ok_nxt = 1'b0;
         w_ok_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_hit ? `ARC_RESP_OKAY : `ARC_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready_i) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_sc1) begin
         ch_nxt = wr_data[`ARC_SC1_CH_MSB:0];
         cont_nxt = wr_data[`ARC_SC1_CONT_BIT];
         aien_nxt = wr_data[`ARC_SC1_AIEN_BIT];
         // Only a write starts a conversion, so single mode stays idle after it ends
         start_nxt = (wr_data[`ARC_SC1_CH_MSB:0] != `ARC_CH_OFF);
      end
      if (wr_cfg) begin
         res_nxt = arc_pkg::arc_res_t'(wr_data[`ARC_CFG_RES_MSB:0]);
         async_nxt = wr_data[`ARC_CFG_ASYNC_BIT];
         // A frozen byte from the old width would no longer pair with anything
         frozen_nxt = 1'b0;
      end
      if (wr_en && wr_b0 && (wr_addr == `ARC_OFF_IMSK)) begin
         imsk_nxt = wr_data[`ARC_IRQ_W-1:0];
      end
      if (wr_en && wr_b0 && (wr_addr == `ARC_OFF_ISTS)) begin
         ists_nxt = ists_r & ~wr_data[`ARC_IRQ_W-1:0];
      end
      if (rd_lo || frozen_r && rd_en && !rd_hi) begin
         frozen_nxt = frozen_nxt;
      end
      if (rd_lo) begin
         frozen_nxt = 1'b0;
      end
      // Low byte is captured from the result before this cycle's completion lands
      if (rd_hi && (res_r != arc_pkg::ARC_RES_8) && !wr_cfg) begin
         frozen_nxt = 1'b1;
         lo_hold_nxt = result_r[7:0];
      end
      if (accept) begin
         result_nxt = conv_masked;
         ists_set[`ARC_IRQ_DONE] = 1'b1;
         ists_set[`ARC_IRQ_OVR] = frozen_r;
      end
      if (accept) begin
         flag_nxt = 1'b1;
      end else if (wr_sc1 || rd_lo) begin
         flag_nxt = 1'b0;
      end
      ists_nxt = ists_nxt | ists_set;
      if (rd_en) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = `ARC_RESP_OKAY;
         rdata_nxt = 32'h0000_0000;
         unique case (s_axi_araddr_i)
            `ARC_OFF_SC1: rdata_nxt[7:0] = {flag_r, aien_r, cont_r, ch_r};
            `ARC_OFF_CFG: rdata_nxt[2:0] = {async_r, res_r};
            `ARC_OFF_RHI: begin
               unique case (res_r)
                  arc_pkg::ARC_RES_12: rdata_nxt[3:0] = result_r[11:8];
                  arc_pkg::ARC_RES_10: rdata_nxt[1:0] = result_r[9:8];
                  default: rdata_nxt[3:0] = 4'h0;
               endcase
            end
            // In 8-bit mode nothing is ever frozen, so the live byte is returned
            `ARC_OFF_RLO: rdata_nxt[7:0] = frozen_r ? lo_hold_r : result_r[7:0];
            `ARC_OFF_ISTS: rdata_nxt[`ARC_IRQ_W-1:0] = ists_r;
            `ARC_OFF_IMSK: rdata_nxt[`ARC_IRQ_W-1:0] = imsk_r;
            default: rresp_nxt = `ARC_RESP_SLVERR;
         endcase
      end else if (rvalid_r && s_axi_rready_i) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aw_ok_r <= 1'b0;
         w_ok_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0000_0000;
         wstrb0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `ARC_RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= `ARC_RESP_OKAY;
         rdata_r <= 32'h0000_0000;
         ch_r <= `ARC_CH_OFF;
         cont_r <= 1'b0;
         aien_r <= 1'b0;
         res_r <= arc_pkg::ARC_RES_8;
         async_r <= 1'b0;
         imsk_r <= `ARC_IMSK_RST;
         start_r <= 1'b0;
         result_r <= '0;
         lo_hold_r <= 8'h00;
         frozen_r <= 1'b0;
         flag_r <= 1'b0;
         ists_r <= '0;
      end else begin
         aw_ok_r <= aw_ok_nxt;
         w_ok_r <= w_ok_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb0_r <= wstrb0_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         ch_r <= ch_nxt;
         cont_r <= cont_nxt;
         aien_r <= aien_nxt;
         res_r <= res_nxt;
         async_r <= async_nxt;
         imsk_r <= imsk_nxt;
         start_r <= start_nxt;
         result_r <= result_nxt;
         lo_hold_r <= lo_hold_nxt;
         frozen_r <= frozen_nxt;
         flag_r <= flag_nxt;
         ists_r <= ists_nxt;
      end
   end

   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = bresp_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rresp_o = rresp_r;
   assign s_axi_rdata_o = rdata_r;
   assign conv_start_o = start_r;
   assign conv_on_o = (ch_r != `ARC_CH_OFF);
   assign conv_cont_o = cont_r;
   assign conv_chan_o = ch_r;
   assign conv_res_o = res_r;
   assign conv_clk_async_o = async_r;
   // Flag left set by a racing write interrupts straight away when enabled
   assign irq_o = (flag_r && aien_r) || |(ists_r & imsk_r);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_flag_set_on_done;
      accept |=> flag_r;
   endproperty
   a_flag_set_on_done: assert property (p_flag_set_on_done) else $error("flag not set");

   property p_write_clears;
      wr_sc1 && !accept |=> !flag_r;
   endproperty
   a_write_clears: assert property (p_write_clears) else $error("write left flag");

   property p_irq_after_write;
      wr_sc1 && accept && wr_data[`ARC_SC1_AIEN_BIT] |=> irq_o && flag_r;
   endproperty
   a_irq_after_write: assert property (p_irq_after_write) else $error("no irq");

   property p_freeze_hold;
      rd_hi && !wr_cfg && res_r != arc_pkg::ARC_RES_8 |=>
         frozen_r && lo_hold_r == $past(result_r[7:0]);
   endproperty
   a_freeze_hold: assert property (p_freeze_hold) else $error("freeze lost");

   // The racing completion lands in the result while the held byte keeps the older one
   property p_race_hold;
      rd_hi && accept && !wr_cfg && res_r != arc_pkg::ARC_RES_8 |=>
         lo_hold_r == $past(result_r[7:0]) && result_r == $past(conv_masked);
   endproperty
   a_race_hold: assert property (p_race_hold) else $error("race broke low byte");

   property p_race_keep;
      rd_hi && accept && !wr_cfg && res_r != arc_pkg::ARC_RES_8 ##1 !wr_cfg[*2] |->
         frozen_r || $past(rd_lo);
   endproperty
   a_race_keep: assert property (p_race_keep) else $error("race dropped freeze");

   property p_eight_bit;
      res_r == arc_pkg::ARC_RES_8 |-> !frozen_r;
   endproperty
   a_eight_bit: assert property (p_eight_bit) else $error("8-bit frozen");

   property p_start_only_on_write;
      !wr_sc1 |=> !conv_start_o;
   endproperty
   a_start_only_on_write: assert property (p_start_only_on_write) else $error("stray start");

   property p_bus_clock_done;
      !async_r && conv_done_i && conv_on_o |=> flag_r && ists_r[`ARC_IRQ_DONE];
   endproperty
   a_bus_clock_done: assert property (p_bus_clock_done) else $error("done lost");

   property p_sc1_fields;
      wr_sc1 |=> conv_chan_o == $past(wr_data[`ARC_SC1_CH_MSB:0]) &&
         conv_cont_o == $past(wr_data[`ARC_SC1_CONT_BIT]);
   endproperty
   a_sc1_fields: assert property (p_sc1_fields) else $error("control not taken");

   property p_release;
      rd_lo |=> !frozen_r;
   endproperty
   a_release: assert property (p_release) else $error("freeze kept");

   c_race: cover property (rd_hi && accept && res_r == arc_pkg::ARC_RES_12);
   c_write_race: cover property (wr_sc1 && accept);
   c_coherent_pair: cover property (rd_hi ##[1:20] rd_lo);
   c_overrun: cover property (accept && frozen_r);

endmodule : arc_core

// ==== testbench/arc_conv_model.sv ====
`timescale 1ns/1ps

// Converter stand-in: lat_i of zero means it only completes on kick_i
module arc_conv_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic on_i,
   input wire logic cont_i,
   input wire logic kick_i,
   input wire logic [3:0] lat_i,
   input wire logic [11:0] val_i,
   output logic done_o,
   output logic tgl_o,
   output logic [11:0] data_o
);
   logic [3:0] cnt_r;
   logic auto_r;

   assign done_o = auto_r | kick_i;
   assign data_o = val_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= 4'h0;
         auto_r <= 1'b0;
         tgl_o <= 1'b0;
      end else begin
         auto_r <= (cnt_r == 4'h1);
         if (start_i && on_i && lat_i != 4'h0)
            cnt_r <= lat_i;
         else if (cnt_r == 4'h1 && cont_i && on_i)
            cnt_r <= lat_i;
         else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
         // Same completions also cross as a toggle for the async path
         if (done_o)
            tgl_o <= ~tgl_o;
      end
   end
endmodule : arc_conv_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`include "arc_cfg.svh"

module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic kick = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [11:0] val = 12'h000;
   logic [3:0] lat = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, cdone, ctgl, start, on, cont, casync, irq;
   logic [1:0] bresp, rresp, res;
   logic [31:0] rdata;
   logic [11:0] cdata;
   logic [4:0] chan;
   int miscompares = 0;
   int num_checks = 0;
   int starts = 0;

   always #12.5 clk = ~clk;
   always @(posedge clk) if (start) starts <= starts + 1;

   arc_core u_dut (.clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .conv_done_i(cdone), .conv_done_tgl_i(ctgl), .conv_data_i(cdata), .conv_start_o(start),
      .conv_on_o(on), .conv_cont_o(cont), .conv_chan_o(chan), .conv_res_o(res),
      .conv_clk_async_o(casync), .irq_o(irq));

   arc_conv_model u_conv (.clk_i(clk), .rst_i(rst), .start_i(start), .on_i(on), .cont_i(cont),
      .kick_i(kick), .lat_i(lat), .val_i(val), .done_o(cdone), .tgl_o(ctgl), .data_o(cdata));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // Race flag puts a completion on the very edge that takes the request
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = `ARC_RESP_OKAY, input logic race = 1'b0);
      logic [1:0] r;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      kick <= race;
      forever begin
         @(posedge clk);
         kick <= 1'b0;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            break;
         end
      end
      bready <= 1'b0;
      chk(32'(r), 32'(er));
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                     input logic race);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      kick <= race;
      forever begin
         @(posedge clk);
         kick <= 1'b0;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            break;
         end
      end
      rready <= 1'b0;
   endtask : rd

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic race = 1'b0);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r, race);
      chk(d, e);
      chk(32'(r), 32'(`ARC_RESP_OKAY));
   endtask : rdc

   task automatic hit(input logic [11:0] v);
      @(posedge clk) val <= v;
      @(posedge clk) kick <= 1'b1;
      @(posedge clk) kick <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : hit

   task automatic t_reset();
      chk(32'(irq), 32'h0000_0000);
      chk(32'(on), 32'h0000_0000);
      chk(32'(chan), 32'h0000_001F);
      rdc(`ARC_OFF_SC1, 32'h0000_001F);
      rdc(`ARC_OFF_CFG, 32'h0000_0000);
      rdc(`ARC_OFF_IMSK, 32'h0000_0000);
   endtask : t_reset

   task automatic t_single();
      @(posedge clk) lat <= 4'h4;
      val <= 12'hABC;
      wr(`ARC_OFF_CFG, 32'h0000_0001);
      wr(`ARC_OFF_SC1, 32'h0000_0003);
      chk(32'(chan), 32'h0000_0003);
      chk(32'(on), 32'h0000_0001);
      chk(32'(cont), 32'h0000_0000);
      repeat (10) @(posedge clk);
      chk(32'(starts), 32'h0000_0001);
      rdc(`ARC_OFF_SC1, 32'h0000_0083);
      repeat (20) @(posedge clk);
      chk(32'(starts), 32'h0000_0001);
      rdc(`ARC_OFF_RHI, 32'h0000_000A);
      rdc(`ARC_OFF_RLO, 32'h0000_00BC);
   endtask : t_single

   task automatic t_cont();
      wr(`ARC_OFF_SC1, 32'h0000_0023);
      chk(32'(cont), 32'h0000_0001);
      repeat (20) @(posedge clk);
      wr(`ARC_OFF_SC1, 32'h0000_001F);
      chk(32'(on), 32'h0000_0000);
      chk(32'(cont), 32'h0000_0000);
   endtask : t_cont

   task automatic t_flag();
      @(posedge clk) lat <= 4'h0;
      wr(`ARC_OFF_SC1, 32'h0000_001F);
      wr(`ARC_OFF_SC1, 32'h0000_0042);
      // Completion only counts while the converter is on, so the race needs a live channel
      wr(`ARC_OFF_SC1, 32'h0000_0042, `ARC_RESP_OKAY, 1'b1);
      chk(32'(irq), 32'h0000_0001);
      rdc(`ARC_OFF_SC1, 32'h0000_00C2);
      wr(`ARC_OFF_SC1, 32'h0000_0042);
      rdc(`ARC_OFF_SC1, 32'h0000_0042);
      chk(32'(irq), 32'h0000_0000);
   endtask : t_flag

   task automatic t_coh();
      wr(`ARC_OFF_CFG, 32'h0000_0002);
      chk(32'(res), 32'(arc_pkg::ARC_RES_10));
      hit(12'h2AA);
      @(posedge clk) val <= 12'h155;
      rdc(`ARC_OFF_RHI, 32'h0000_0002, 1'b1);
      rdc(`ARC_OFF_RLO, 32'h0000_00AA);
      rdc(`ARC_OFF_RHI, 32'h0000_0001);
      rdc(`ARC_OFF_RLO, 32'h0000_0055);
   endtask : t_coh

   task automatic t_8bit();
      wr(`ARC_OFF_CFG, 32'h0000_0000);
      hit(12'h0C3);
      @(posedge clk) val <= 12'h05A;
      rdc(`ARC_OFF_RHI, 32'h0000_0000, 1'b1);
      rdc(`ARC_OFF_RLO, 32'h0000_005A);
   endtask : t_8bit

   task automatic t_irq();
      logic [31:0] d;
      logic [1:0] r;
      wr(`ARC_OFF_SC1, 32'h0000_0002);
      wr(`ARC_OFF_ISTS, 32'h0000_0003);
      wr(`ARC_OFF_IMSK, 32'h0000_0001);
      chk(32'(irq), 32'h0000_0000);
      hit(12'h111);
      chk(32'(irq), 32'h0000_0001);
      rdc(`ARC_OFF_ISTS, 32'h0000_0001);
      wr(`ARC_OFF_IMSK, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      wr(`ARC_OFF_IMSK, 32'h0000_0001);
      wr(`ARC_OFF_ISTS, 32'h0000_0001);
      chk(32'(irq), 32'h0000_0000);
      rdc(`ARC_OFF_ISTS, 32'h0000_0000);
      rd(8'h20, d, r, 1'b0);
      chk(d, 32'h0000_0000);
      chk(32'(r), 32'(`ARC_RESP_SLVERR));
      wr(8'h20, 32'h0000_0001, `ARC_RESP_SLVERR);
   endtask : t_irq

   task automatic t_async();
      wr(`ARC_OFF_CFG, 32'h0000_0005);
      chk(32'(casync), 32'h0000_0001);
      wr(`ARC_OFF_SC1, 32'h0000_0002);
      hit(12'h9E1);
      repeat (6) @(posedge clk);
      rdc(`ARC_OFF_SC1, 32'h0000_0082);
      rdc(`ARC_OFF_RHI, 32'h0000_0009);
      rdc(`ARC_OFF_RLO, 32'h0000_00E1);
   endtask : t_async

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_single();
      t_cont();
      t_flag();
      t_coh();
      t_8bit();
      t_irq();
      t_async();
      stop_test();
   end

   // The whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      stop_test();
   end
endmodule : tb
